// [design/line_interface_monitor_los_logic.sv]
// Control, drive monitor, clock lock, code violation and loss-of-signal logic
//
// The placing of the registers and the Wishbone slave port are this design's own decisions.
`timescale 1ns/10ps
module line_interface_monitor_los_logic import lim_pkg::*; #(
  parameter int LOS_COUNT = LOS_CNT,
  parameter int DMON_COUNT = DMON_CNT
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [3:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  input wire logic HOST_MODE_I,
  input wire logic TRANSMIT_INPUT_CLOCK_I,
  input wire logic TX_DATA_POSITIVE_I,
  input wire logic TX_DATA_NEGATIVE_I,
  input wire logic MONITOR_IN_POSITIVE_I,
  input wire logic MONITOR_IN_NEGATIVE_I,
  input wire logic RECOVERED_CLOCK_I,
  input wire logic REFERENCE_CLOCK_IN_I,
  input wire logic LINE_IN_POSITIVE_I,
  input wire logic LINE_IN_NEGATIVE_I,
  input wire logic ANALOG_SIGNAL_LOSS_I,
  input wire logic TRANSMITTER_ENABLE_I,
  input wire logic EQUALIZER_SELECT_I,
  input wire logic RECEIVE_MONITOR_GAIN_ENABLE_I,
  input wire logic RAIL_FORMAT_SELECT_I,
  input wire logic MUTE_ON_LOSS_I,
  input wire logic BUILD_OUT_SELECT_I,
  input wire logic E3_MODE_I,
  output logic LINE_OUT_POSITIVE_O,
  output logic LINE_OUT_NEGATIVE_O,
  output logic LINE_OUT_OE_O,
  output logic DRIVE_FAULT_OUT_O,
  output logic BUILD_OUT_SELECT_O,
  output logic EQUALIZER_SELECT_O,
  output logic RECEIVE_MONITOR_GAIN_ENABLE_O,
  output logic LOSS_OF_LOCK_O,
  output logic RECEIVE_OUTPUT_CLOCK_O,
  output logic RECOVERED_DATA_POSITIVE_O,
  output logic RECOVERED_DATA_NEGATIVE_O,
  output logic CODE_VIOLATION_OUT_O,
  output logic COMBINED_SIGNAL_LOSS_O
);
  if (LOS_COUNT < 100 || LOS_COUNT > 250 || DMON_COUNT < 96 || DMON_COUNT > 160) begin : g_bad
    $error("Loss or drive monitor count outside documented range");
  end

  function automatic logic pick(input logic host, input logic bit_v, input logic pin_v);
    return host ? bit_v : pin_v;
  endfunction

  // Pin synchroniser: stage 1 is seen only by stage 2
  logic [NS-1:0] s1_ff, s2_ff, s3_ff, f_ff, fp_ff;
  logic [NS-1:0] pins;
  assign pins = {HOST_MODE_I, E3_MODE_I, BUILD_OUT_SELECT_I, MUTE_ON_LOSS_I, RAIL_FORMAT_SELECT_I,
                 RECEIVE_MONITOR_GAIN_ENABLE_I, EQUALIZER_SELECT_I, TRANSMITTER_ENABLE_I,
                 ANALOG_SIGNAL_LOSS_I, LINE_IN_NEGATIVE_I, LINE_IN_POSITIVE_I,
                 REFERENCE_CLOCK_IN_I, RECOVERED_CLOCK_I, MONITOR_IN_NEGATIVE_I,
                 MONITOR_IN_POSITIVE_I, TX_DATA_NEGATIVE_I, TX_DATA_POSITIVE_I,
                 TRANSMIT_INPUT_CLOCK_I};
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      f_ff <= '0;
      fp_ff <= '0;
    end else begin
      s1_ff <= pins;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      f_ff <= (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & f_ff);
      fp_ff <= f_ff;
    end
  end
  logic txc_evt, rec_evt, ref_evt, host_ff;
  assign txc_evt = f_ff[S_TXC] & ~fp_ff[S_TXC];
  assign rec_evt = f_ff[S_REC] & ~fp_ff[S_REC];
  assign ref_evt = f_ff[S_REF] & ~fp_ff[S_REF];
  assign host_ff = f_ff[S_HOST];

  // Wishbone slave: ack one cycle after request, dropped the next cycle
  ctrl_t ctrl_ff;
  stat_t stat;
  logic req;
  assign req = CYC_I & STB_I & ~ACK_O;
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) ACK_O <= 1'b0;
    else ACK_O <= req;
  end
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) ctrl_ff <= CTRL_RST;
    else if (req && WE_I && ADR_I == CTRL_OFS) begin
      if (SEL_I[0]) ctrl_ff[7:0] <= DAT_I[7:0];
      if (SEL_I[1]) ctrl_ff[CTRL_W-1] <= DAT_I[CTRL_W-1];
    end
  end
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) DAT_O <= '0;
    else if (req && !WE_I) begin
      case (ADR_I)
        CTRL_OFS: DAT_O <= {{(32-CTRL_W){1'b0}}, ctrl_ff};
        STAT_OFS: DAT_O <= {{(32-STAT_W){1'b0}}, stat};
        default: DAT_O <= '0;
      endcase
    end
  end
  // Effective selections
  logic single_rail, tx_on, eq_on, gain_on, mute_on, los_off;
  assign single_rail = pick(host_ff, ctrl_ff.single_rail, f_ff[S_RAIL]);
  assign tx_on = f_ff[S_TRANSMITTER_ENABLE] & (~host_ff | ctrl_ff.tx_en);
  assign eq_on = pick(host_ff, ctrl_ff.eq, f_ff[S_EQ]);
  assign gain_on = ctrl_ff.rx_gain | f_ff[S_RXM];
  assign mute_on = pick(host_ff, ctrl_ff.mute, f_ff[S_MUTE]);
  assign los_off = ctrl_ff.los_dis_ana & ctrl_ff.los_dis_dig;
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      BUILD_OUT_SELECT_O <= 1'b0;
      EQUALIZER_SELECT_O <= 1'b0;
      RECEIVE_MONITOR_GAIN_ENABLE_O <= 1'b0;
    end else begin
      BUILD_OUT_SELECT_O <= pick(host_ff, ctrl_ff.build_out, f_ff[S_BO]);
      EQUALIZER_SELECT_O <= eq_on;
      RECEIVE_MONITOR_GAIN_ENABLE_O <= gain_on;
    end
  end

  // Transmit driver; data pins are driven only while enabled
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      LINE_OUT_POSITIVE_O <= 1'b0;
      LINE_OUT_NEGATIVE_O <= 1'b0;
      LINE_OUT_OE_O <= 1'b0;
    end else begin
      LINE_OUT_POSITIVE_O <= tx_on & f_ff[S_TXP];
      LINE_OUT_NEGATIVE_O <= tx_on & f_ff[S_TXN];
      LINE_OUT_OE_O <= tx_on;
    end
  end

  // Drive monitor: own outputs or the external monitor pair
  logic mon_p, mon_n, mon_pp, mon_np, mon_evt;
  logic [7:0] dm_cnt_ff;
  assign mon_p = ctrl_ff.int_mon ? LINE_OUT_POSITIVE_O : f_ff[S_MP];
  assign mon_n = ctrl_ff.int_mon ? LINE_OUT_NEGATIVE_O : f_ff[S_MN];
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      mon_pp <= 1'b0;
      mon_np <= 1'b0;
    end else begin
      mon_pp <= mon_p;
      mon_np <= mon_n;
    end
  end
  assign mon_evt = (mon_p & ~mon_pp) | (mon_n & ~mon_np);
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      dm_cnt_ff <= '0;
      DRIVE_FAULT_OUT_O <= 1'b0;
    end else if (mon_evt) begin
      dm_cnt_ff <= '0;
      DRIVE_FAULT_OUT_O <= 1'b0;
    end else if (txc_evt && dm_cnt_ff != 8'(DMON_COUNT)) begin
      dm_cnt_ff <= dm_cnt_ff + 8'h01;
      if (dm_cnt_ff == 8'(DMON_COUNT - 1)) DRIVE_FAULT_OUT_O <= 1'b1;
    end
  end

  // Lock monitor: recovered edges counted over a window of reference edges
  logic [10:0] ref_cnt_ff, rec_cnt_ff;
  logic freq_bad_ff;
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      ref_cnt_ff <= '0;
      rec_cnt_ff <= '0;
      freq_bad_ff <= 1'b1;
    end else if (ref_evt && ref_cnt_ff == 11'(LOCK_WIN - 1)) begin
      ref_cnt_ff <= '0;
      rec_cnt_ff <= '0;
      freq_bad_ff <= rec_cnt_ff < 11'(LOCK_WIN - LOCK_TOL) ||
                     rec_cnt_ff > 11'(LOCK_WIN + LOCK_TOL);
    end else begin
      if (ref_evt) ref_cnt_ff <= ref_cnt_ff + 11'h001;
      if (rec_evt && rec_cnt_ff != 11'h7ff) rec_cnt_ff <= rec_cnt_ff + 11'h001;
    end
  end

  // Receive decoder and loss detectors; decoder and digital loss stepped per recovered bit
  logic lp, ln, pulse, last_pol_ff, bpv;
  logic [7:0] zrun_ff, win_cnt_ff, ones_ff, ana_cnt_ff;
  logic [2:0] zmax;
  logic digital_signal_loss_ff, analog_signal_loss_ff;
  assign lp = f_ff[S_LP];
  assign ln = f_ff[S_LN];
  assign pulse = lp | ln;
  assign zmax = f_ff[S_E3] ? 3'(ZEROS_HDB3) : 3'(ZEROS_B3ZS);
  // Same polarity as the last mark is legal only after a substitution gap
  assign bpv = pulse && (lp == last_pol_ff) &&
               !(zrun_ff == 8'(zmax - 3'h2) || zrun_ff == 8'(zmax - 3'h1));
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      zrun_ff <= '0;
      last_pol_ff <= 1'b0;
      CODE_VIOLATION_OUT_O <= 1'b0;
      RECOVERED_DATA_POSITIVE_O <= 1'b0;
      RECOVERED_DATA_NEGATIVE_O <= 1'b0;
    end else if (rec_evt) begin
      zrun_ff <= pulse ? 8'h00 : (zrun_ff == 8'hff ? zrun_ff : zrun_ff + 8'h01);
      if (pulse) last_pol_ff <= lp;
      CODE_VIOLATION_OUT_O <= !single_rail &&
        (bpv || (!pulse && zrun_ff == 8'(zmax - 3'h1)));
      RECOVERED_DATA_POSITIVE_O <= lp & ~(COMBINED_SIGNAL_LOSS_O & mute_on);
      RECOVERED_DATA_NEGATIVE_O <= ln & ~(COMBINED_SIGNAL_LOSS_O & mute_on);
    end else begin
      CODE_VIOLATION_OUT_O <= 1'b0;
    end
  end

  // Digital loss: zero run to declare, density over a window to clear
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I || los_off || f_ff[S_E3]) begin
      digital_signal_loss_ff <= 1'b0;
      win_cnt_ff <= '0;
      ones_ff <= '0;
    end else if (rec_evt) begin
      if (!digital_signal_loss_ff) begin
        if (!pulse && zrun_ff == 8'(LOS_COUNT - 1)) digital_signal_loss_ff <= 1'b1;
      end else if (win_cnt_ff == 8'(LOS_COUNT - 1)) begin
        win_cnt_ff <= '0;
        ones_ff <= '0;
        if (32'(ones_ff + 8'(pulse)) * 100 > 32'(LOS_COUNT * DENS_PCT))
          digital_signal_loss_ff <= 1'b0;
      end else begin
        win_cnt_ff <= win_cnt_ff + 8'h01;
        ones_ff <= ones_ff + 8'(pulse);
      end
    end
  end

  // Analog loss; in E3 the level indicator must persist 175 bit periods
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I || los_off) begin
      analog_signal_loss_ff <= 1'b0;
      ana_cnt_ff <= '0;
    end else if (!f_ff[S_E3]) begin
      analog_signal_loss_ff <= f_ff[S_ANALOG_SIGNAL_LOSS];
      ana_cnt_ff <= '0;
    end else if (f_ff[S_ANALOG_SIGNAL_LOSS] == analog_signal_loss_ff) begin
      ana_cnt_ff <= '0;
    end else if (analog_signal_loss_ff ? rec_evt : ref_evt) begin
      // Recovered clock may stop on loss, so declaring counts reference periods only
      if (ana_cnt_ff == 8'(LOS_COUNT - 1)) begin
        analog_signal_loss_ff <= f_ff[S_ANALOG_SIGNAL_LOSS];
        ana_cnt_ff <= '0;
      end else begin
        ana_cnt_ff <= ana_cnt_ff + 8'h01;
      end
    end
  end
  // Combined loss, lock and receive clock selection
  logic combined_signal_loss;
  assign combined_signal_loss = digital_signal_loss_ff | analog_signal_loss_ff;
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      COMBINED_SIGNAL_LOSS_O <= 1'b0;
      LOSS_OF_LOCK_O <= 1'b1;
      RECEIVE_OUTPUT_CLOCK_O <= 1'b0;
    end else begin
      COMBINED_SIGNAL_LOSS_O <= combined_signal_loss;
      LOSS_OF_LOCK_O <= freq_bad_ff | combined_signal_loss;
      RECEIVE_OUTPUT_CLOCK_O <= LOSS_OF_LOCK_O ? f_ff[S_REF] : f_ff[S_REC];
    end
  end
  assign stat = '{drive_fault: DRIVE_FAULT_OUT_O, comb: COMBINED_SIGNAL_LOSS_O,
                  ana: analog_signal_loss_ff, dig: digital_signal_loss_ff, lock: LOSS_OF_LOCK_O};

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  sequence s_zero_bit;
    rec_evt && !pulse;
  endsequence
  sequence s_los_end;
    !digital_signal_loss_ff && zrun_ff == 8'(LOS_COUNT - 1) && !los_off && !f_ff[S_E3];
  endsequence

  fault_low_a: assert property (mon_evt |=> !DRIVE_FAULT_OUT_O)
    else $error("drive fault high after monitor transition");
  fault_rise_a: assert property (!mon_evt && txc_evt && dm_cnt_ff == 8'(DMON_COUNT - 1)
    |=> DRIVE_FAULT_OUT_O)
    else $error("drive fault not raised after timeout");
  tx_tristate_a: assert property (!tx_on |=> !LINE_OUT_OE_O && !LINE_OUT_POSITIVE_O &&
    !LINE_OUT_NEGATIVE_O)
    else $error("line driven while transmitter off");
  tx_host_a: assert property (host_ff && !ctrl_ff.tx_en |=> !LINE_OUT_OE_O)
    else $error("host bit clear but transmitter on");
  eq_sel_a: assert property (##1 EQUALIZER_SELECT_O == $past(eq_on))
    else $error("equalizer select mismatch");
  gain_sel_a: assert property ($rose(f_ff[S_RXM]) |=> RECEIVE_MONITOR_GAIN_ENABLE_O)
    else $error("monitor gain not enabled");
  refclk_out_a: assert property (LOSS_OF_LOCK_O |=>
    RECEIVE_OUTPUT_CLOCK_O == $past(f_ff[S_REF]))
    else $error("reference clock not output in training");
  cv_pulse_a: assert property (CODE_VIOLATION_OUT_O |=> !CODE_VIOLATION_OUT_O)
    else $error("violation pulse longer than one cycle");
  comb_or_a: assert property (##1 COMBINED_SIGNAL_LOSS_O == $past(digital_signal_loss_ff || analog_signal_loss_ff))
    else $error("combined loss not OR of losses");
  digital_signal_loss_set_a: assert property (s_los_end ##0 s_zero_bit |=> digital_signal_loss_ff)
    else $error("digital loss not declared after zero run");
  mute_a: assert property (rec_evt && COMBINED_SIGNAL_LOSS_O && mute_on
    |=> !RECOVERED_DATA_POSITIVE_O && !RECOVERED_DATA_NEGATIVE_O)
    else $error("data not muted on loss");
endmodule

// [design/lim_pkg.sv]
// Constants, register map and carriers of the line interface monitor block
package lim_pkg;
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  // Control word, MSB first: bit 0 selects single-rail format
  typedef struct packed {
    logic los_dis_dig;
    logic los_dis_ana;
    logic mute;
    logic rx_gain;
    logic eq;
    logic tx_en;
    logic int_mon;
    logic build_out;
    logic single_rail;
  } ctrl_t;
  localparam int CTRL_W = 9;
  localparam ctrl_t CTRL_RST = 9'h000;
  typedef struct packed {
    logic drive_fault;
    logic comb;
    logic ana;
    logic dig;
    logic lock;
  } stat_t;
  localparam int STAT_W = 5;
  localparam stat_t STAT_RST = 5'h00;
  // Synchroniser slots of pin inputs
  localparam int NS = 18;
  localparam int S_TXC = 0, S_TXP = 1, S_TXN = 2, S_MP = 3, S_MN = 4;
  localparam int S_REC = 5, S_REF = 6, S_LP = 7, S_LN = 8, S_ANALOG_SIGNAL_LOSS = 9;
  localparam int S_TRANSMITTER_ENABLE = 10, S_EQ = 11, S_RXM = 12, S_RAIL = 13;
  localparam int S_MUTE = 14, S_BO = 15, S_E3 = 16, S_HOST = 17;
  // Timing in line bit periods and reference edges
  localparam int DMON_CNT = 128;
  localparam int LOS_CNT = 175;
  localparam int DENS_PCT = 33;
  localparam int LOCK_WIN = 1000;
  localparam int LOCK_PPT = 5;
  localparam int LOCK_TOL = LOCK_WIN * LOCK_PPT / 1000;
  localparam int ZEROS_B3ZS = 3;
  localparam int ZEROS_HDB3 = 4;
endpackage

// [dv/line_partner.sv]
// Behavioural line side: link clocks, receive rails and transmit monitor pair
`timescale 1ns/10ps
module line_partner (
  input wire logic [1:0] pattern_i,
  input wire logic mon_run_i,
  output logic rec_clk_o,
  output logic ref_clk_o,
  output logic tx_clk_o,
  output logic line_p_o,
  output logic line_n_o,
  output logic mon_p_o,
  output logic mon_n_o
);
  logic pol;
  initial begin
    {rec_clk_o, ref_clk_o, tx_clk_o, line_p_o, line_n_o, mon_p_o, mon_n_o, pol} = 8'h00;
  end
  // Odd offsets keep the link clocks out of phase with the block clock
  initial begin
    #3;
    forever #40 rec_clk_o = ~rec_clk_o;
  end
  initial begin
    #17;
    forever #40 ref_clk_o = ~ref_clk_o;
  end
  initial begin
    #29;
    forever #40 tx_clk_o = ~tx_clk_o;
  end
  // Pattern 0 alternate marks, 1 all zeros, 2 same-polarity marks only
  always @(negedge rec_clk_o) begin
    pol = ~pol;
    line_p_o = (pattern_i == 2'd0) ? pol : (pattern_i == 2'd2);
    line_n_o = (pattern_i == 2'd0) ? ~pol : 1'b0;
  end
  // A dead driver leaves the monitor pair still, not floating
  always @(posedge tx_clk_o) begin
    if (mon_run_i) begin
      mon_p_o = ~mon_p_o;
      mon_n_o = ~mon_p_o;
    end
  end
endmodule

// [dv/line_interface_monitor_los_logic_tb.sv]
// Self-checking bench of the line interface monitor block
`timescale 1ns/10ps
module line_interface_monitor_los_logic_tb;
  import lim_pkg::*;
  localparam int LOSN = 100;
  localparam int DMN = 100;
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic host = 1'b0, txp = 1'b0, txn = 1'b0, analog_signal_loss = 1'b0, transmitter_enable = 1'b0, eqp = 1'b0;
  logic rxm = 1'b0, rail = 1'b0, mutep = 1'b0, bo = 1'b0, e3 = 1'b0, mon_run = 1'b1;
  logic [1:0] pat = 2'd0;
  logic rec, refc, txc, lp, ln, mp, mn, lop, lon, oe, fault, bo_o, eq_o, gain_o;
  logic lol, receive_output_clock, rdp, rdn, cv, los;
  logic cv_prev = 1'b0, seen_data = 1'b0;
  int num_errors = 0, checks_done = 0, cycles = 0, cv_cnt = 0;

  always #5 clk = ~clk;

  line_interface_monitor_los_logic #(.LOS_COUNT(LOSN), .DMON_COUNT(DMN)) dut (
    .CLK_I(clk), .RST_N_I(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
    .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .HOST_MODE_I(host),
    .TRANSMIT_INPUT_CLOCK_I(txc), .TX_DATA_POSITIVE_I(txp), .TX_DATA_NEGATIVE_I(txn),
    .MONITOR_IN_POSITIVE_I(mp), .MONITOR_IN_NEGATIVE_I(mn), .RECOVERED_CLOCK_I(rec),
    .REFERENCE_CLOCK_IN_I(refc), .LINE_IN_POSITIVE_I(lp), .LINE_IN_NEGATIVE_I(ln),
    .ANALOG_SIGNAL_LOSS_I(analog_signal_loss), .TRANSMITTER_ENABLE_I(transmitter_enable), .EQUALIZER_SELECT_I(eqp),
    .RECEIVE_MONITOR_GAIN_ENABLE_I(rxm), .RAIL_FORMAT_SELECT_I(rail),
    .MUTE_ON_LOSS_I(mutep), .BUILD_OUT_SELECT_I(bo), .E3_MODE_I(e3),
    .LINE_OUT_POSITIVE_O(lop), .LINE_OUT_NEGATIVE_O(lon), .LINE_OUT_OE_O(oe),
    .DRIVE_FAULT_OUT_O(fault), .BUILD_OUT_SELECT_O(bo_o), .EQUALIZER_SELECT_O(eq_o),
    .RECEIVE_MONITOR_GAIN_ENABLE_O(gain_o), .LOSS_OF_LOCK_O(lol),
    .RECEIVE_OUTPUT_CLOCK_O(receive_output_clock), .RECOVERED_DATA_POSITIVE_O(rdp),
    .RECOVERED_DATA_NEGATIVE_O(rdn), .CODE_VIOLATION_OUT_O(cv),
    .COMBINED_SIGNAL_LOSS_O(los));

  line_partner partner (.pattern_i(pat), .mon_run_i(mon_run), .rec_clk_o(rec),
    .ref_clk_o(refc), .tx_clk_o(txc), .line_p_o(lp), .line_n_o(ln), .mon_p_o(mp),
    .mon_n_o(mn));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic cyc_w(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic bits(input int n);
    cyc_w(8 * n);
  endtask

  // Classic single cycle; entered just after a rising edge
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    // A hung slave is ended by the bench-wide cycle ceiling
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  // Violation pulses are counted; two in a row would mean a stretched pulse
  always @(posedge clk) begin
    cycles++;
    if (cv === 1'b1) cv_cnt++;
    if (cv === 1'b1 && cv_prev === 1'b1) chk(cv, 1'b0);
    cv_prev <= cv;
    if (rdp === 1'b1 || rdn === 1'b1) seen_data = 1'b1;
    if (cycles > 70000) begin
      num_errors++;
      final_report();
    end
  end

  initial begin
    cyc_w(12);
    rst_n <= 1'b1;
    cyc_w(1);
    chk(lol, 1'b1);
    wb(1'b0, CTRL_OFS, 32'h0, q);
    chk(q, CTRL_RST);
    wb(1'b1, CTRL_OFS, 32'h1ff, q);
    wb(1'b0, CTRL_OFS, 32'h0, q);
    chk(q, 32'h1ff);
    wb(1'b1, 4'hc, 32'hffff_ffff, q);
    wb(1'b0, 4'hc, 32'h0, q);
    chk(q, 32'h0);
    wb(1'b1, CTRL_OFS, 32'h0, q);
    transmitter_enable <= 1'b1;
    eqp <= 1'b1;
    bo <= 1'b1;
    cyc_w(8);
    chk({oe, eq_o, gain_o, bo_o}, 4'b1101);
    host <= 1'b1;
    rxm <= 1'b1;
    cyc_w(8);
    chk({oe, eq_o, gain_o}, 3'b001);
    wb(1'b1, CTRL_OFS, 32'h018, q);
    rxm <= 1'b0;
    cyc_w(8);
    chk({oe, eq_o, gain_o}, 3'b110);
    transmitter_enable <= 1'b0;
    wb(1'b1, CTRL_OFS, 32'h020, q);
    cyc_w(8);
    chk({oe, eq_o, gain_o}, 3'b001);
    bits(2200);
    chk(lol, 1'b0);
    chk(fault, 1'b0);
    mon_run <= 1'b0;
    bits(DMN - 12);
    chk(fault, 1'b0);
    bits(30);
    chk(fault, 1'b1);
    mon_run <= 1'b1;
    bits(2);
    chk(fault, 1'b0);
    // Own driver is off and still, so the toggling external pair must be ignored
    wb(1'b1, CTRL_OFS, 32'h024, q);
    bits(DMN + 30);
    chk(fault, 1'b1);
    wb(1'b1, CTRL_OFS, 32'h0, q);
    cv_cnt = 0;
    bits(40);
    chk(cv_cnt, 0);
    pat <= 2'd2;
    bits(4);
    cv_cnt = 0;
    bits(20);
    chk(cv_cnt >= 15, 1'b1);
    wb(1'b1, CTRL_OFS, 32'h1, q);
    bits(4);
    cv_cnt = 0;
    bits(20);
    chk(cv_cnt, 0);
    wb(1'b1, CTRL_OFS, 32'h0, q);
    pat <= 2'd1;
    cv_cnt = 0;
    bits(LOSN - 20);
    chk(los, 1'b0);
    chk(cv_cnt > 0, 1'b1);
    bits(30);
    chk({los, lol}, 2'b11);
    wb(1'b0, STAT_OFS, 32'h0, q);
    chk(q & 32'h0b, 32'h0b);
    pat <= 2'd0;
    bits(LOSN + 60);
    chk(los, 1'b0);
    analog_signal_loss <= 1'b1;
    bits(2);
    chk(los, 1'b1);
    seen_data = 1'b0;
    bits(10);
    chk(seen_data, 1'b1);
    wb(1'b1, CTRL_OFS, 32'h040, q);
    bits(2);
    seen_data = 1'b0;
    bits(10);
    chk(seen_data, 1'b0);
    wb(1'b1, CTRL_OFS, 32'h180, q);
    bits(2);
    chk(los, 1'b0);
    analog_signal_loss <= 1'b0;
    wb(1'b1, CTRL_OFS, 32'h0, q);
    e3 <= 1'b1;
    bits(5);
    analog_signal_loss <= 1'b1;
    bits(9);
    chk(los, 1'b0);
    bits(240);
    chk(los, 1'b1);
    analog_signal_loss <= 1'b0;
    bits(9);
    chk(los, 1'b1);
    bits(240);
    chk(los, 1'b0);
    final_report();
  end
endmodule
